// ---- hdl/hvf_pkg.sv ----
// package for the holdover, validation and tuning word control block
// assumes an apb slave with 32-bit data and byte addresses
package hvf_pkg;

    // ==========================================================
    // register byte addresses
    localparam logic [7:0] HVF_CTRL_ADDR     = 8'h00;
    localparam logic [7:0] HVF_TIMER_ADDR    = 8'h04;
    localparam logic [7:0] HVF_STATUS_ADDR   = 8'h08;
    localparam logic [7:0] HVF_TRACE_LO_ADDR = 8'h0C;
    localparam logic [7:0] HVF_TRACE_HI_ADDR = 8'h10;
    localparam logic [7:0] HVF_UPPER_LO_ADDR = 8'h14;
    localparam logic [7:0] HVF_UPPER_HI_ADDR = 8'h18;
    localparam logic [7:0] HVF_LOWER_LO_ADDR = 8'h1C;
    localparam logic [7:0] HVF_LOWER_HI_ADDR = 8'h20;

    // ==========================================================
    // widths and field positions
    localparam int HVF_TW_W        = 48;
    localparam int HVF_HI_W        = 16;
    localparam int HVF_CODE_W      = 5;
    localparam int HVF_LEN_W       = 4;
    localparam int HVF_VCNT_W      = 33;
    localparam int HVF_SCNT_W      = 17;
    localparam int HVF_ACC_W       = 64;
    localparam int HVF_CTRL_W      = 7;
    localparam int HVF_LEN_LSB     = 8;
    localparam int HVF_NREF        = 2;

    // ==========================================================
    // reset values
    localparam logic [47:0] HVF_UPPER_RST = 48'h8000_0000_0000; // half the sample clock
    localparam logic [47:0] HVF_LOWER_RST = 48'h0000_0000_0000; // zero frequency
    localparam logic [4:0]  HVF_CODE_RST  = 5'h00;
    localparam logic [3:0]  HVF_LEN_RST   = 4'h0;

    // ==========================================================
    // control register layout, bit 6 first
    typedef struct packed {
        logic auto_revert;    // [6] state machine may return to a valid reference
        logic use_average;    // [5] holdover word from averager, else last loop word
        logic avg_select;     // [4] averaging path instead of pass-through
        logic hsa_enable;     // [3] sampler/averager runs
        logic holdover_mode;  // [2] forced holdover level
        logic override_en;    // [1] override state machine in auto mode
        logic auto_holdover;  // [0] 0 manual pin, 1 state machine
    } hvf_ctrl_t;

    localparam hvf_ctrl_t HVF_CTRL_RST = '0;

    // loop-rate sample from the loop filter
    typedef struct packed {
        logic        tick;   // one pulse per loop-filter sample period
        logic [47:0] word;   // loop filter tuning word for that sample
    } hvf_loop_t;

    typedef enum logic [1:0] {
        HVF_REF_A,
        HVF_REF_B,
        HVF_HOLD_A,
        HVF_HOLD_B
    } hvf_state_t;

endpackage : hvf_pkg

// ---- hdl/hvf_ctrl.sv ----
// holdover control, reference validation timers, sampler/averager, tuning word clamp
// assumes pclk is the divided dac sample clock domain; fault and holdover pins are async
//
// Function
// - each reference has its own validation timer, status goes to state machine.
// - timer starts only once both lost and out-of-limit faults clear.
// - timer expiry flags that reference valid and selectable.
// - valid reference is switched to from holdover only when control bits allow it.
// - both timers share one 5-bit interval code, reset zero.
// - interval lasts 2^(code+1)-1 loop-filter sample periods.
// - in holdover loop control stops and a static tuning word is applied.
// - control bit picks averaged word or last valid word on holdover entry.
// - manual holdover release restarts loop starting from the holdover word.
// - automatic exit switches to whichever reference becomes valid first, reference A when both are valid.
// - enabled averager collects loop filter outputs continuously.
// - averager output goes to a read-only trace register and holdover logic.
// - holdover entry uses the averager output delivered before the latest one, from the last stage.
// - default mode passes samples unchanged at the loop-filter rate.
// - averaging mode takes block means over 2^(Y+1) samples, Y 4-bit.
// - finished averages enter a two-stage pipeline, last stage used.
// - pipeline delay is one block, held value is one to two blocks old.
// - tuning word clipped to programmable 48-bit upper and lower limits.
// - after reset upper limit is half sample clock, lower is zero.
// - configuration bit picks manual pin control or state machine control.
// - override forces holdover state, pin still shows state machine choice.
//
// Our own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module hvf_ctrl
    import hvf_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              clk_en,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [1:0]        reference_lost,
    input  wire logic [1:0]        reference_out_of_limit,
    input  wire logic              holdover_pin_i,
    output logic                   holdover_pin_o,
    output logic                   holdover_pin_oe,
    input  wire hvf_loop_t         loop_in,
    output logic [HVF_TW_W-1:0]    tuning_word,
    output logic                   loop_hold,
    output logic                   loop_restart,
    output logic [HVF_TW_W-1:0]    loop_seed,
    output logic [1:0]             reference_valid,
    output logic                   ref_select_b
);

    // ==========================================================
    // pin synchronisers
    logic [4:0] sync1_q;
    logic [4:0] sync2_q;

    // two flops per async input, only the second stage is read
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else if (clk_en) begin
            sync1_q <= {holdover_pin_i, reference_out_of_limit, reference_lost};
            sync2_q <= sync1_q;
        end
    end

    wire [1:0] lost_s     = sync2_q[1:0];
    wire [1:0] ool_s      = sync2_q[3:2];
    wire       hold_pin_s = sync2_q[4];
    wire [1:0] fault      = lost_s | ool_s;

    // ==========================================================
    // register file
    hvf_ctrl_t            ctrl_q;
    logic [4:0]           code_q;
    logic [3:0]           len_q;
    logic [HVF_TW_W-1:0]  upper_q;
    logic [HVF_TW_W-1:0]  lower_q;
    logic [HVF_TW_W-1:0]  trace_q;

    wire wr_en = psel & penable & pwrite & clk_en;

    // software writes, only whole-word stores on a completed access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q  <= HVF_CTRL_RST;
            code_q  <= HVF_CODE_RST;
            len_q   <= HVF_LEN_RST;
            upper_q <= HVF_UPPER_RST;
            lower_q <= HVF_LOWER_RST;
        end else if (wr_en) begin
            unique case (paddr)
                HVF_CTRL_ADDR:     ctrl_q <= hvf_ctrl_t'(pwdata[HVF_CTRL_W-1:0]);
                HVF_TIMER_ADDR: begin
                    code_q <= pwdata[HVF_CODE_W-1:0];
                    len_q  <= pwdata[HVF_LEN_LSB +: HVF_LEN_W];
                end
                HVF_UPPER_LO_ADDR: upper_q[31:0]  <= pwdata;
                HVF_UPPER_HI_ADDR: upper_q[47:32] <= pwdata[HVF_HI_W-1:0];
                HVF_LOWER_LO_ADDR: lower_q[31:0]  <= pwdata;
                HVF_LOWER_HI_ADDR: lower_q[47:32] <= pwdata[HVF_HI_W-1:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // validation timers, one per reference; each bit driven by its own generate block
    wire  [1:0] valid_q;
    wire  [HVF_VCNT_W-1:0] vlimit =
        (HVF_VCNT_W'(1) << (HVF_VCNT_W'(code_q) + HVF_VCNT_W'(1))) - HVF_VCNT_W'(1);

    genvar gi;
    generate
        for (gi = 0; gi < HVF_NREF; gi++) begin : g_vtimer
            logic [HVF_VCNT_W-1:0] cnt_q;
            logic                  vld_q;
            wire  [HVF_VCNT_W-1:0] cnt_inc = cnt_q + HVF_VCNT_W'(1);

            // counts loop ticks only while both faults are clear
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q <= '0;
                    vld_q <= 1'b0;
                end else if (clk_en) begin
                    if (fault[gi]) begin
                        cnt_q <= '0;
                        vld_q <= 1'b0;
                    end else if (!vld_q && loop_in.tick) begin
                        cnt_q <= cnt_inc;
                        if (cnt_inc == vlimit) begin
                            vld_q <= 1'b1;
                        end
                    end
                end
            end

            assign valid_q[gi] = vld_q;
        end
    endgenerate

    assign reference_valid = valid_q;

    // ==========================================================
    // holdover and reference state machine
    hvf_state_t state_q;
    hvf_state_t state_d;

    wire sm_hold  = (state_q == HVF_HOLD_A) || (state_q == HVF_HOLD_B);
    wire sm_ref_b = (state_q == HVF_REF_B)  || (state_q == HVF_HOLD_B);

    // a failing active reference moves to the other if valid, else holdover
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            HVF_REF_A: begin
                if (fault[0]) begin
                    state_d = valid_q[1] ? HVF_REF_B : HVF_HOLD_A;
                end
            end
            HVF_REF_B: begin
                if (fault[1]) begin
                    state_d = valid_q[0] ? HVF_REF_A : HVF_HOLD_B;
                end
            end
            HVF_HOLD_A, HVF_HOLD_B: begin
                // leaving holdover only when recovery is permitted
                if (ctrl_q.auto_revert) begin
                    if (valid_q[0]) begin
                        state_d = HVF_REF_A;
                    end else if (valid_q[1]) begin
                        state_d = HVF_REF_B;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= HVF_REF_A;
        end else if (clk_en) begin
            state_q <= state_d;
        end
    end

    // manual pin, state machine, or register override
    wire hold_auto = ctrl_q.override_en ? ctrl_q.holdover_mode : sm_hold;
    wire hold_eff  = ctrl_q.auto_holdover ? hold_auto : hold_pin_s;

    // pin becomes an output in auto mode and shows the machine's own choice
    assign holdover_pin_oe = ctrl_q.auto_holdover;
    assign holdover_pin_o  = sm_hold;
    assign ref_select_b    = sm_ref_b;

    // ==========================================================
    // holdover sampler/averager
    logic [HVF_ACC_W-1:0]  acc_q;
    logic [HVF_SCNT_W-1:0] scnt_q;
    logic [HVF_TW_W-1:0]   pipe1_q;
    logic [HVF_TW_W-1:0]   pipe2_q;
    logic [1:0]            pvalid_q;

    wire [HVF_SCNT_W-1:0] blk_len  =
        HVF_SCNT_W'(1) << (HVF_SCNT_W'(len_q) + HVF_SCNT_W'(1));
    wire [HVF_SCNT_W-1:0] scnt_inc = scnt_q + HVF_SCNT_W'(1);
    wire [HVF_ACC_W-1:0]  acc_sum  = acc_q + HVF_ACC_W'(loop_in.word);
    wire [HVF_ACC_W-1:0]  avg_full = acc_sum >> (HVF_ACC_W'(len_q) + HVF_ACC_W'(1));
    wire                  blk_done = (scnt_inc == blk_len);
    wire                  sample   = ctrl_q.hsa_enable & loop_in.tick;
    wire                  deliver  = sample & (~ctrl_q.avg_select | blk_done);
    wire [HVF_TW_W-1:0]   hsa_out  =
        ctrl_q.avg_select ? avg_full[HVF_TW_W-1:0] : loop_in.word;

    // accumulate in the background; a disabled averager restarts its block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc_q  <= '0;
            scnt_q <= '0;
        end else if (clk_en) begin
            if (!ctrl_q.hsa_enable || !ctrl_q.avg_select) begin
                acc_q  <= '0;
                scnt_q <= '0;
            end else if (sample) begin
                acc_q  <= blk_done ? '0 : acc_sum;
                scnt_q <= blk_done ? '0 : scnt_inc;
            end
        end
    end

    // finished results shift through two stages, holdover reads the last
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pipe1_q  <= '0;
            pipe2_q  <= '0;
            pvalid_q <= 2'b00;
            trace_q  <= '0;
        end else if (clk_en && deliver) begin
            pipe1_q  <= hsa_out;
            pipe2_q  <= pipe1_q;
            pvalid_q <= {pvalid_q[0], 1'b1};
            trace_q  <= hsa_out;
        end
    end

    // ==========================================================
    // static word, restart and clamp
    logic                 hold_q;
    logic [HVF_TW_W-1:0]  last_word_q;
    logic [HVF_TW_W-1:0]  static_q;
    logic                 restart_q;
    logic [HVF_TW_W-1:0]  tw_q;

    wire hold_enter = hold_eff & ~hold_q;
    wire hold_exit  = ~hold_eff & hold_q;
    // averaged source only once the last stage holds a finished result
    wire use_avg    = ctrl_q.use_average & pvalid_q[1];
    wire [HVF_TW_W-1:0] hold_src = use_avg ? pipe2_q : last_word_q;

    // last word is only refreshed outside holdover so it stays valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_q      <= 1'b0;
            last_word_q <= '0;
            static_q    <= '0;
            restart_q   <= 1'b0;
        end else if (clk_en) begin
            hold_q    <= hold_eff;
            restart_q <= hold_exit & ~ctrl_q.auto_holdover;
            if (loop_in.tick && !hold_eff) begin
                last_word_q <= loop_in.word;
            end
            if (hold_enter) begin
                static_q <= hold_src;
            end
        end
    end

    wire [HVF_TW_W-1:0] tw_raw  = hold_q ? static_q : loop_in.word;
    wire [HVF_TW_W-1:0] tw_clip =
        (tw_raw > upper_q) ? upper_q :
        (tw_raw < lower_q) ? lower_q : tw_raw;

    // registered so the dds sees one clean word per cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tw_q <= HVF_LOWER_RST;
        end else if (clk_en) begin
            tw_q <= tw_clip;
        end
    end

    assign tuning_word  = tw_q;
    assign loop_hold    = hold_q;
    assign loop_restart = restart_q;
    assign loop_seed    = static_q;

    // ==========================================================
    // apb read side, zero wait states
    wire [31:0] status_w = {27'h0, sm_ref_b, sm_hold, hold_q, valid_q};
    wire        rd_hit   = (paddr == HVF_CTRL_ADDR)     || (paddr == HVF_TIMER_ADDR)
                        || (paddr == HVF_STATUS_ADDR)   || (paddr == HVF_TRACE_LO_ADDR)
                        || (paddr == HVF_TRACE_HI_ADDR) || (paddr == HVF_UPPER_LO_ADDR)
                        || (paddr == HVF_UPPER_HI_ADDR) || (paddr == HVF_LOWER_LO_ADDR)
                        || (paddr == HVF_LOWER_HI_ADDR);

    // read data is only meaningful while the access phase is up
    always_comb begin
        unique case (paddr)
            HVF_CTRL_ADDR:     prdata = {25'h0, ctrl_q};
            HVF_TIMER_ADDR:    prdata = {20'h0, len_q, 3'h0, code_q};
            HVF_STATUS_ADDR:   prdata = status_w;
            HVF_TRACE_LO_ADDR: prdata = trace_q[31:0];
            HVF_TRACE_HI_ADDR: prdata = {16'h0, trace_q[47:32]};
            HVF_UPPER_LO_ADDR: prdata = upper_q[31:0];
            HVF_UPPER_HI_ADDR: prdata = {16'h0, upper_q[47:32]};
            HVF_LOWER_LO_ADDR: prdata = lower_q[31:0];
            HVF_LOWER_HI_ADDR: prdata = {16'h0, lower_q[47:32]};
            default:           prdata = 32'h0000_0000;
        endcase
    end

    // no wait states; a frozen clock enable stalls the bus instead
    assign pready  = clk_en;
    assign pslverr = psel & penable & ~rd_hit;

endmodule : hvf_ctrl

// ---- dv/hvf_checker.sv ----
// concurrent checks on the hvf_ctrl ports: apb answer, validation timers, holdover
// assumes clk_en stays high apart from short stalls; bound to every hvf_ctrl instance
`timescale 1ns/100ps
module hvf_checker
    import hvf_pkg::*;
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                clk_en,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [1:0]          reference_lost,
    input wire logic [1:0]          reference_out_of_limit,
    input wire logic                holdover_pin_i,
    input wire logic                holdover_pin_oe,
    input wire hvf_loop_t           loop_in,
    input wire logic [HVF_TW_W-1:0] tuning_word,
    input wire logic                loop_hold,
    input wire logic                loop_restart,
    input wire logic [1:0]          reference_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ==========================================================
    // steps: five cycles cover the two sync flops plus the register
    sequence s_fault_a;
        (clk_en && (reference_lost[0] || reference_out_of_limit[0])) [*5];
    endsequence
    sequence s_fault_b;
        (clk_en && (reference_lost[1] || reference_out_of_limit[1])) [*5];
    endsequence
    sequence s_pin_high;
        (clk_en && !holdover_pin_oe && holdover_pin_i) [*5];
    endsequence
    sequence s_pin_low;
        (clk_en && !holdover_pin_oe && !holdover_pin_i) [*5];
    endsequence

    // ==========================================================
    // properties
    property p_valid_a; s_fault_a |-> !reference_valid[0]; endproperty
    property p_valid_b; s_fault_b |-> !reference_valid[1]; endproperty
    property p_valid_tick; $rose(reference_valid[0]) |-> $past(loop_in.tick); endproperty
    property p_hold_on; s_pin_high |-> loop_hold; endproperty
    property p_hold_off; s_pin_low |-> !loop_hold; endproperty
    property p_restart;
        loop_restart |-> (!loop_hold && $past(loop_hold)) ##1 !loop_restart;
    endproperty
    property p_static; loop_hold [*3] |-> $stable(tuning_word); endproperty
    property p_ready; psel && penable |-> pready == clk_en; endproperty
    property p_err; psel && penable && paddr > 8'h20 |-> pslverr && prdata == 32'h0; endproperty
    property p_err_phase; pslverr |-> psel && penable; endproperty

    a_valid_a: assert property (p_valid_a) else $error("ref a valid while faulted");
    a_valid_b: assert property (p_valid_b) else $error("ref b valid while faulted");
    a_valid_tick: assert property (p_valid_tick) else $error("valid without tick");
    a_hold_on: assert property (p_hold_on) else $error("pin high, no hold");
    a_hold_off: assert property (p_hold_off) else $error("pin low, still hold");
    a_restart: assert property (p_restart) else $error("bad restart pulse");
    a_static: assert property (p_static) else $error("word moved in holdover");
    a_ready: assert property (p_ready) else $error("pready not clk_en");
    a_err: assert property (p_err) else $error("unmapped access not refused");
    a_err_phase: assert property (p_err_phase) else $error("pslverr outside access");
endmodule : hvf_checker

bind hvf_ctrl hvf_checker u_chk (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .reference_lost(reference_lost), .reference_out_of_limit(reference_out_of_limit),
    .holdover_pin_i(holdover_pin_i), .holdover_pin_oe(holdover_pin_oe), .loop_in(loop_in),
    .tuning_word(tuning_word), .loop_hold(loop_hold), .loop_restart(loop_restart),
    .reference_valid(reference_valid)
);

// ---- dv/holdover_validation_ftw_control_test.sv ----
// self-checking bench for hvf_ctrl: registers, clamp, validation, averager, holdover
// assumes hvf_pkg and the bound checker are compiled ahead of this file
`timescale 1ns/100ps
module holdover_validation_ftw_control_test
    import hvf_pkg::*;
;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        clk_en = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  reference_lost = 2'h3;
    logic [1:0]  reference_out_of_limit = 2'h3;
    logic        holdover_pin_i = 1'b0;
    logic        holdover_pin_o;
    logic        holdover_pin_oe;
    hvf_loop_t   loop_in = '0;
    logic [47:0] tuning_word;
    logic        loop_hold;
    logic        loop_restart;
    logic [47:0] loop_seed;
    logic [1:0]  reference_valid;
    logic        ref_select_b;
    logic [31:0] rd;
    logic        err;
    logic [47:0] v48;
    logic [47:0] cw [3] = '{48'h8, 48'h2000, 48'h345};
    logic [47:0] ce [3] = '{48'h10, 48'h1000, 48'h345};
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          pulses;

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    hvf_ctrl DUT (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reference_lost(reference_lost),
        .reference_out_of_limit(reference_out_of_limit), .holdover_pin_i(holdover_pin_i),
        .holdover_pin_o(holdover_pin_o), .holdover_pin_oe(holdover_pin_oe),
        .loop_in(loop_in), .tuning_word(tuning_word), .loop_hold(loop_hold),
        .loop_restart(loop_restart), .loop_seed(loop_seed),
        .reference_valid(reference_valid), .ref_select_b(ref_select_b)
    );

    // ==========================================================
    // tasks
    task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; waits on pready, released one edge later
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // halves are independent, so order matters only for moving values
    task automatic wr48(input logic [7:0] lo, input logic [7:0] hi, input logic [47:0] v);
        apb(1'b1, lo, v[31:0]);
        apb(1'b1, hi, {16'h0, v[47:32]});
    endtask : wr48

    task automatic rd48(input logic [7:0] lo, input logic [7:0] hi);
        apb(1'b0, lo, 32'h0);
        v48[31:0] = rd;
        apb(1'b0, hi, 32'h0);
        v48[47:32] = rd[15:0];
    endtask : rd48

    task automatic tick(input logic [47:0] w, input int n);
        repeat (n) begin
            loop_in <= '{tick: 1'b1, word: w};
            @(posedge pclk);
            loop_in.tick <= 1'b0;
            @(posedge pclk);
        end
    endtask : tick

    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask : cyc

    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : close_out

    // ==========================================================
    // tests
    initial begin : main
        cyc(6);
        presetn <= 1'b1;
        cyc(1);
        rd48(HVF_UPPER_LO_ADDR, HVF_UPPER_HI_ADDR);
        chk(v48, HVF_UPPER_RST);
        rd48(HVF_LOWER_LO_ADDR, HVF_LOWER_HI_ADDR);
        chk(v48, HVF_LOWER_RST);
        apb(1'b0, HVF_TIMER_ADDR, 32'h0);
        chk(48'(rd), 48'h0);
        chk(48'(holdover_pin_oe), 48'h0);
        apb(1'b0, 8'h24, 32'h0);
        chk(48'(err), 48'h1);
        $display("test reset done");
        // clamp against defaults, then against narrow limits
        loop_in.word <= 48'hFFFF_FFFF_FFFF;
        cyc(3);
        chk(tuning_word, HVF_UPPER_RST);
        wr48(HVF_UPPER_LO_ADDR, HVF_UPPER_HI_ADDR, 48'h1000);
        wr48(HVF_LOWER_LO_ADDR, HVF_LOWER_HI_ADDR, 48'h10);
        for (int i = 0; i < 3; i++) begin
            loop_in.word <= cw[i];
            cyc(3);
            chk(tuning_word, ce[i]);
        end
        $display("test clamp done");
        // T=2 gives 7 ticks; B keeps out-of-limit at first
        apb(1'b1, HVF_TIMER_ADDR, 32'h0000_0102);
        reference_lost <= 2'h0;
        cyc(3);
        tick(48'h100, 8);
        chk(48'(reference_valid), 48'h0);
        reference_out_of_limit <= 2'h2;
        cyc(3);
        tick(48'h100, 6);
        chk(48'(reference_valid), 48'h0);
        tick(48'h100, 1);
        chk(48'(reference_valid), 48'h1);
        reference_out_of_limit <= 2'h0;
        cyc(3);
        tick(48'h100, 4);
        reference_lost <= 2'h2;
        cyc(4);
        reference_lost <= 2'h0;
        cyc(3);
        tick(48'h100, 6);
        chk(48'(reference_valid), 48'h1);
        tick(48'h100, 1);
        chk(48'(reference_valid), 48'h3);
        $display("test validation done");
        // pass-through trace, then averages of 4 with a cut block
        apb(1'b1, HVF_CTRL_ADDR, 32'h08);
        tick(48'h777, 2);
        rd48(HVF_TRACE_LO_ADDR, HVF_TRACE_HI_ADDR);
        chk(v48, 48'h777);
        apb(1'b1, HVF_CTRL_ADDR, 32'h38);
        for (int i = 1; i <= 4; i++)
            tick(48'(i * 256), 1);
        tick(48'h800, 4);
        tick(48'hF00, 2);
        holdover_pin_i <= 1'b1;
        cyc(6);
        chk(48'(loop_hold), 48'h1);
        chk(tuning_word, 48'h280);
        tick(48'hFFF, 2);
        chk(tuning_word, 48'h280);
        holdover_pin_i <= 1'b0;
        pulses = 0;
        repeat (8) begin
            @(posedge pclk);
            if (loop_restart === 1'b1)
                pulses++;
        end
        chk(48'(pulses), 48'h1);
        chk(48'(loop_hold), 48'h0);
        chk(loop_seed, 48'h280);
        $display("test averager done");
        // last loop word taken on a tick, not the untaken word
        apb(1'b1, HVF_CTRL_ADDR, 32'h08);
        tick(48'h333, 1);
        loop_in.word <= 48'h444;
        holdover_pin_i <= 1'b1;
        cyc(6);
        chk(tuning_word, 48'h333);
        holdover_pin_i <= 1'b0;
        cyc(6);
        $display("test last word done");
        // automatic control, override and revert
        apb(1'b1, HVF_CTRL_ADDR, 32'h41);
        cyc(4);
        chk(48'(holdover_pin_oe), 48'h1);
        chk(48'(holdover_pin_o), 48'h0);
        apb(1'b1, HVF_CTRL_ADDR, 32'h47);
        cyc(4);
        chk(48'(loop_hold), 48'h1);
        chk(48'(holdover_pin_o), 48'h0);
        apb(1'b1, HVF_CTRL_ADDR, 32'h01);
        reference_lost <= 2'h1;
        cyc(6);
        chk(48'(ref_select_b), 48'h1);
        reference_lost <= 2'h3;
        cyc(6);
        chk(48'(holdover_pin_o), 48'h1);
        reference_lost <= 2'h1;
        cyc(3);
        tick(48'h100, 7);
        chk(48'(reference_valid), 48'h2);
        chk(48'(holdover_pin_o), 48'h1);
        apb(1'b1, HVF_CTRL_ADDR, 32'h41);
        cyc(4);
        chk(48'(holdover_pin_o), 48'h0);
        chk(48'(ref_select_b), 48'h1);
        apb(1'b0, HVF_STATUS_ADDR, 32'h0);
        chk(48'(rd), 48'h12);
        $display("test auto done");
        close_out();
    end

    // cut a hang short; the run needs well under 10 us
    initial begin : watchdog
        #100000;
        n_mismatch++;
        close_out();
    end
endmodule : holdover_validation_ftw_control_test
